// ==== bench/dstg_pixel_source.sv ====
// Purpose: Pixel source standing in for the frame store behind the block.
// Assumes: pix_data is taken on the edge where pix_req rises.
// Notes:   Upper ten bits are all ones so a wrong TV lane map shows up.
`timescale 1ns/1ns
module dstg_pixel_source (
   // System
   input wire logic clk,
   input wire logic rstn,
   // Pixel link
   input wire logic pix_req,
   output logic [17:0] pix_data
);
   logic [6:0] seq;
   logic [6:0] next_seq;
   always_comb begin
      next_seq = pix_req ? seq + 7'h01 : seq;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seq <= 7'h00;
      end else begin
         seq <= next_seq;
      end
   end
   // Byte stays below 80h, so bit 7 on the TV lanes proves the mapping
   assign pix_data = {10'h3FF, 1'b0, seq};
endmodule

// ==== bench/dstg_top_bench.sv ====
// Purpose: Self-checking bench for the display sync timing generator.
// Assumes: Register access over classic Wishbone, one 125 MHz clock.
// Notes:   Edge times are measured in base cycles from the vsync rise.
`timescale 1ns/1ns
module dstg_top_bench;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, pix_req, pixel_clock, hsync, vsync, data_enable, line_start_pulse;
   logic gate_clock_signal, power_save_signal, polarity_flip_signal;
   logic tv_output_clock, tv_line_sync, tv_field_sync, tv_data_valid;
   logic [17:0] pix_data, ld;
   logic [10:0] mon, prev = 11'h0;
   logic tv_on = 1'b0;
   int cyc = 0, failures = 0, n_compared = 0, n_dv = 0;
   int a, b, c, d, co;
   logic [31:0] q;
   always #4 clk = ~clk;
   assign mon = {tv_output_clock, tv_field_sync, tv_line_sync, pixel_clock,
      polarity_flip_signal, power_save_signal, gate_clock_signal, line_start_pulse,
      data_enable, vsync, hsync};
   dstg_top i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_data(pix_data), .pix_req(pix_req),
      .pixel_clock(pixel_clock), .hsync(hsync), .vsync(vsync), .data_enable(data_enable),
      .line_start_pulse(line_start_pulse), .gate_clock_signal(gate_clock_signal),
      .power_save_signal(power_save_signal), .polarity_flip_signal(polarity_flip_signal),
      .ld(ld), .tv_output_clock(tv_output_clock), .tv_line_sync(tv_line_sync),
      .tv_field_sync(tv_field_sync), .tv_data_valid(tv_data_valid));
   dstg_pixel_source i_src (.clk(clk), .rstn(rstn), .pix_req(pix_req), .pix_data(pix_data));
   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rng(input int got, input int lo, input int hi);
      chk(32'(got), (got >= lo && got <= hi) ? 32'(got) : 32'(lo));
   endtask
   task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic setup(input logic [31:0] clkcfg, input logic [11:0] div,
                        input logic [3:0] ctrl);
      wb_xfer(dstg_pkg::REG_CLKCFG, 1'b1, clkcfg);
      wb_xfer(dstg_pkg::REG_DIV, 1'b1, {20'h0, div});
      wb_xfer(dstg_pkg::REG_CTRL, 1'b1, {28'h0, ctrl});
   endtask
   function automatic logic [31:0] pk(input int hi, input int lo);
      return {4'h0, 12'(hi), 4'h0, 12'(lo)};
   endfunction
   // Edge of mon[i]: v=0 fall, v=1 rise, v=2 either
   task automatic nxt(input int i, input int v, output int t);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!((v == 2) ? mon[i] != prev[i] : (mon[i] == v[0] && prev[i] != v[0]))
                 && n < 3000);
      if (n >= 3000) failures++;
      t = cyc;
   endtask
   task automatic meas(input int i, input int v, output int dd);
      int t0, t;
      nxt(1, 1, t0);
      nxt(i, v, t);
      dd = t - t0;
   endtask
   // ----------------------------------------------------------------
   // Edge history, hang guard and TV stream watch
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      prev <= mon;
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         give_verdict();
      end
   end
   always @(posedge clk) begin
      if (tv_on && tv_data_valid === 1'b0) begin
         n_dv++;
         chk(32'(tv_line_sync), 32'h1);
         // Byte stands on the strobe of the pixel that fetched it
         if (tv_output_clock === 1'b1) begin
            chk(32'(ld), 32'({pix_data[7:0], 10'h000}));
         end
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      chk(32'({power_save_signal, tv_line_sync, tv_field_sync, tv_data_valid, hsync,
         vsync, data_enable}), 32'h78);
      wb_xfer(dstg_pkg::REG_CTRL, 1'b0, 32'h0);
      chk(q, dstg_pkg::RST_CTRL);
      wb_xfer(dstg_pkg::REG_CLKCFG, 1'b0, 32'h0);
      chk(q, 32'h001B_007D);
      wb_xfer(8'h30, 1'b1, 32'hFFFF_FFFF);
      wb_xfer(8'h30, 1'b0, 32'h0);
      chk(q, 32'h0);
      wb_xfer(dstg_pkg::REG_STAT, 1'b1, 32'h0123_0456);
      wb_xfer(dstg_pkg::REG_STAT, 1'b0, 32'h0);
      chk(q, 32'h0);
      wb_xfer(dstg_pkg::REG_HLINE, 1'b1, pk(2, 9));
      wb_xfer(dstg_pkg::REG_HPOS, 1'b1, pk(2, 3));
      wb_xfer(dstg_pkg::REG_AWFH, 1'b1, pk(3, 5));
      wb_xfer(dstg_pkg::REG_VSYNC, 1'b1, pk(1, 1));
      wb_xfer(dstg_pkg::REG_AHGR, 1'b1, pk(1, 1));
      wb_xfer(dstg_pkg::REG_GFPF, 1'b1, pk(2, 5));
      wb_xfer(dstg_pkg::REG_PRRV, 1'b1, pk(4, 6));
      setup(32'h0001_0001, 12'h001, 4'h9);
      nxt(7, 1, a);
      nxt(7, 1, b);
      chk(32'(b - a), 32'h2);
      meas(0, 1, d);
      chk(32'(d), 32'h6);
      a = cyc;
      nxt(0, 0, b);
      chk(32'(b - a), 32'h6);
      nxt(0, 1, c);
      chk(32'(c - a), 32'd20);
      nxt(1, 1, a);
      nxt(1, 0, b);
      nxt(1, 1, c);
      chk(32'(b - a), 32'd40);
      chk(32'(c - a), 32'd80);
      meas(2, 1, d);
      chk(32'(d), 32'd24);
      a = cyc;
      nxt(2, 0, b);
      nxt(2, 1, c);
      chk(32'(b - a), 32'd10);
      chk(32'(c - a), 32'd80);
      meas(3, 1, d);
      chk(32'(d % 20), 32'h2);
      meas(4, 1, d);
      chk(32'(d), 32'h2);
      meas(4, 0, d);
      chk(32'(d), 32'd10);
      meas(5, 0, d);
      chk(32'(d), 32'h4);
      meas(5, 1, d);
      chk(32'(d), 32'd12);
      meas(6, 2, d);
      chk(32'(d), 32'h8);
      wb_xfer(dstg_pkg::REG_CTRL, 1'b1, 32'h1);
      nxt(1, 1, a);
      nxt(1, 0, b);
      chk(32'(b - a), 32'h4);
      for (int k = 0; k < 2; k++) begin
         setup(k ? 32'h0001_0001 : 32'h0001_0002, k ? 12'h002 : 12'h001, 4'h9);
         nxt(7, 1, a);
         nxt(7, 1, a);
         nxt(7, 1, b);
         chk(32'(b - a), k ? 32'h3 : 32'h4);
      end
      setup(32'h0002_0005, 12'h000, 4'h9);
      nxt(7, 1, a);
      c = a;
      for (int k = 0; k < 4; k++) begin
         nxt(7, 1, b);
         rng(b - c, 2, 3);
         c = b;
      end
      chk(32'(c - a), 32'd10);
      setup(32'h0001_0001, 12'h001, 4'hB);
      nxt(0, 1, a);
      nxt(0, 1, b);
      chk(32'(b - a), 32'd20);
      tv_on = 1'b1;
      setup(32'h001B_007D, 12'h000, 4'h5);
      nxt(10, 1, a);
      repeat (27) nxt(10, 1, b);
      rng(b - a, 113, 137);
      nxt(8, 0, a);
      nxt(8, 1, b);
      nxt(8, 0, c);
      rng(b - a, 4, 5);
      rng(c - a, 45, 48);
      nxt(9, 0, a);
      co = (prev[8] && !mon[8]) ? 1 : 0;
      nxt(9, 1, b);
      rng(b - a, 4, 2000);
      nxt(9, 0, c);
      co += (prev[8] && !mon[8]) ? 1 : 0;
      chk(32'(co), 32'h1);
      rng(n_dv, 1, LIMIT);
      tv_on = 1'b0;
      wb_xfer(dstg_pkg::REG_CTRL, 1'b1, 32'h0);
      repeat (3) @(posedge clk);
      wb_xfer(dstg_pkg::REG_STAT, 1'b0, 32'h0);
      chk(q, 32'h0);
      chk(32'({power_save_signal, tv_line_sync, tv_field_sync, tv_data_valid, hsync,
         vsync, data_enable}), 32'h78);
      give_verdict();
   end
endmodule

// ==== common/dstg_pkg.sv ====
// Purpose: Shared constants for the display sync timing generator.
// Assumes: 125 MHz base clock, classic Wishbone register access.
// Notes:   Register offsets are byte addresses of 32-bit words.
package dstg_pkg;
   // ----------------------------------------------------------------
   // Clock figures
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 125;
   localparam int TV_CLK_MHZ = 27;
   localparam int TV_CLK_TOL_PCT = 10;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CLKCFG = 8'h04;
   localparam logic [7:0] REG_DIV = 8'h08;
   localparam logic [7:0] REG_HLINE = 8'h0C;
   localparam logic [7:0] REG_HPOS = 8'h10;
   localparam logic [7:0] REG_AWFH = 8'h14;
   localparam logic [7:0] REG_VSYNC = 8'h18;
   localparam logic [7:0] REG_AHGR = 8'h1C;
   localparam logic [7:0] REG_GFPF = 8'h20;
   localparam logic [7:0] REG_PRRV = 8'h24;
   localparam logic [7:0] REG_STAT = 8'h28;
   localparam logic [7:0] REG_STAT2 = 8'h2C;
   localparam int NUM_CFG = 10;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_VUNIT_BIT = 3;
   localparam int FLD_LO = 0;
   localparam int FLD_HI = 16;
   // ----------------------------------------------------------------
   // Modes and reset values
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DSTG_PANEL = 2'b00,
      DSTG_SMART = 2'b01,
      DSTG_TV = 2'b10
   } dstg_mode_t;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [15:0] RST_IPER = 16'(SYS_CLK_MHZ);
   localparam logic [15:0] RST_BPER = 16'(TV_CLK_MHZ);
   localparam logic [31:0] RST_CFG = 32'h0000_0000;
endpackage

// ==== verilog/dstg_top.sv ====
// Purpose: Display sync timing generator, panel and TV encoder modes.
// Assumes: Pixel data arrives on clk, sampled on the edge where pix_req rises.
// Notes:   Output clocks are one-base-cycle strobes at the pixel rate.
//
// Operation
// - pixel period is (divider+1) interface periods
// - line lasts line width plus one pixels
// - hsync lasts hsync width plus one pixels
// - blanks around active width from start x
// - hsync starts after hsync delay pixels
// - frame lasts frame height plus one lines
// - vsync width plus one, pixels or lines
// - vertical blanks around active height from start y
// - interface period follows fractional period ratio
// - gate clock rises and falls at delays
// - polarity flip toggles at its delay
// - smart display mode times like panel mode
// - TV byte on data lines 17 to 10
// - TV output clock near 27 MHz
// - TV syncs and data valid active low
// - TV line sync low one clock per row
// - TV field sync falls at each field
// - odd field: both syncs fall together
// - even field: syncs fall apart
// - TV data only while line sync high
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module dstg_top #(
   parameter int W = 12
) (
   // System
   input wire logic clk,
   input wire logic rstn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pixel source
   input wire logic [17:0] pix_data,
   output logic pix_req,
   // Panel port
   output logic pixel_clock,
   output logic hsync,
   output logic vsync,
   output logic data_enable,
   output logic line_start_pulse,
   output logic gate_clock_signal,
   output logic power_save_signal,
   output logic polarity_flip_signal,
   output logic [17:0] ld,
   // TV encoder port
   output logic tv_output_clock,
   output logic tv_line_sync,
   output logic tv_field_sync,
   output logic tv_data_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [31:0] cfg [0:dstg_pkg::NUM_CFG-1];
   logic [31:0] next_cfg [0:dstg_pkg::NUM_CFG-1];
   logic [31:0] next_dat;
   logic next_ack;
   logic [W-1:0] hcnt;
   logic [W-1:0] vcnt;
   logic field;
   logic [3:0] idx;

   assign idx = wb_adr_i[5:2];

   always_comb begin
      next_cfg = cfg;
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_dat = 32'h0000_0000;
      // Write lands on the edge where the master sees ack
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && idx < 4'(dstg_pkg::NUM_CFG)) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               next_cfg[idx][8*b +: 8] = wb_dat_i[8*b +: 8];
            end
         end
      end
      if (next_ack && !wb_we_i) begin
         if (idx < 4'(dstg_pkg::NUM_CFG)) begin
            next_dat = cfg[idx];
         end else if (wb_adr_i == dstg_pkg::REG_STAT) begin
            next_dat[dstg_pkg::FLD_LO +: W] = hcnt;
            next_dat[dstg_pkg::FLD_HI +: W] = vcnt;
         end else if (wb_adr_i == dstg_pkg::REG_STAT2) begin
            next_dat[0] = field;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < dstg_pkg::NUM_CFG; i++) begin
            cfg[i] <= dstg_pkg::RST_CFG;
         end
         cfg[dstg_pkg::REG_CLKCFG[5:2]] <= {dstg_pkg::RST_BPER, dstg_pkg::RST_IPER};
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         cfg <= next_cfg;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // Field views
   logic en;
   logic vunit;
   dstg_pkg::dstg_mode_t mode;
   logic tv;
   logic [15:0] iper;
   logic [15:0] bper;
   logic [W-1:0] pdiv, lw, hsw, hsd, asx, aw, fh, vsw, asy, ah;
   logic [W-1:0] gr, gf, pf, pr, rvd;

   assign en = cfg[0][dstg_pkg::CTRL_EN_BIT];
   assign vunit = cfg[0][dstg_pkg::CTRL_VUNIT_BIT];
   assign mode = dstg_pkg::dstg_mode_t'(cfg[0][dstg_pkg::CTRL_MODE_LSB +: 2]);
   assign tv = (mode == dstg_pkg::DSTG_TV);
   assign iper = cfg[1][15:0];
   assign bper = cfg[1][31:16];
   assign pdiv = cfg[2][dstg_pkg::FLD_LO +: W];
   assign lw = cfg[3][dstg_pkg::FLD_LO +: W];
   assign hsw = cfg[3][dstg_pkg::FLD_HI +: W];
   assign hsd = cfg[4][dstg_pkg::FLD_LO +: W];
   assign asx = cfg[4][dstg_pkg::FLD_HI +: W];
   assign aw = cfg[5][dstg_pkg::FLD_LO +: W];
   assign fh = cfg[5][dstg_pkg::FLD_HI +: W];
   assign vsw = cfg[6][dstg_pkg::FLD_LO +: W];
   assign asy = cfg[6][dstg_pkg::FLD_HI +: W];
   assign ah = cfg[7][dstg_pkg::FLD_LO +: W];
   assign gr = cfg[7][dstg_pkg::FLD_HI +: W];
   assign gf = cfg[8][dstg_pkg::FLD_LO +: W];
   assign pf = cfg[8][dstg_pkg::FLD_HI +: W];
   assign pr = cfg[9][dstg_pkg::FLD_LO +: W];
   assign rvd = cfg[9][dstg_pkg::FLD_HI +: W];

   // ----------------------------------------------------------------
   // Interface and pixel clock dividers
   // ----------------------------------------------------------------
   logic [16:0] acc, next_acc;
   logic [W-1:0] div_cnt, next_div_cnt;
   logic if_tick, pix_tick;
   logic [16:0] acc_sum;

   always_comb begin
      acc_sum = acc + {1'b0, bper};
      next_acc = acc;
      next_div_cnt = div_cnt;
      if_tick = 1'b0;
      pix_tick = 1'b0;
      if (!en) begin
         next_acc = 17'h0_0000;
         next_div_cnt = '0;
      end else begin
         // Ratio of periods; remainder carries so the average is exact
         if (acc_sum >= {1'b0, iper}) begin
            if_tick = 1'b1;
            // Period cut below the remainder: restart the remainder
            if (acc >= {1'b0, iper}) begin
               next_acc = 17'h0_0000;
            end else begin
               next_acc = acc_sum - {1'b0, iper};
            end
         end else begin
            next_acc = acc_sum;
         end
         if (if_tick) begin
            if (div_cnt >= pdiv) begin
               pix_tick = 1'b1;
               next_div_cnt = '0;
            end else begin
               next_div_cnt = div_cnt + W'(1);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc <= 17'h0_0000;
         div_cnt <= '0;
      end else begin
         acc <= next_acc;
         div_cnt <= next_div_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Line and frame counters
   // ----------------------------------------------------------------
   logic [W-1:0] next_hcnt, next_vcnt;
   logic next_field;

   always_comb begin
      next_hcnt = hcnt;
      next_vcnt = vcnt;
      next_field = field;
      if (!en) begin
         next_hcnt = '0;
         next_vcnt = '0;
         next_field = 1'b0;
      end else if (pix_tick) begin
         if (hcnt >= lw) begin
            next_hcnt = '0;
            if (vcnt >= fh) begin
               next_vcnt = '0;
               next_field = !field;
            end else begin
               next_vcnt = vcnt + W'(1);
            end
         end else begin
            next_hcnt = hcnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hcnt <= '0;
         vcnt <= '0;
         field <= 1'b0;
      end else begin
         hcnt <= next_hcnt;
         vcnt <= next_vcnt;
         field <= next_field;
      end
   end

   // ----------------------------------------------------------------
   // Output decode
   // ----------------------------------------------------------------
   logic next_pclk, next_hs, next_vs, next_de, next_lsp, next_gate, next_ps, next_rev;
   logic next_tvls, next_tvfs, next_tvdv, next_req;
   logic [17:0] next_ld;
   logic h_act, v_act;
   logic [W-1:0] hs_end, vfs_start, asx_m1;

   assign hs_end = hsd + hsw;
   assign asx_m1 = asx - W'(1);
   assign vfs_start = {1'b0, lw[W-1:1]} + W'(1);

   always_comb begin
      h_act = (hcnt >= asx) && (hcnt < asx + aw);
      v_act = (vcnt >= asy) && (vcnt < asy + ah);
      next_pclk = pix_tick;
      next_hs = 1'b0;
      next_vs = 1'b0;
      next_de = 1'b0;
      next_lsp = 1'b0;
      next_gate = 1'b0;
      next_ps = 1'b1;
      next_rev = polarity_flip_signal;
      next_tvls = 1'b1;
      next_tvfs = 1'b1;
      next_tvdv = 1'b1;
      next_req = 1'b0;
      next_ld = ld;
      if (en && !tv) begin
         // Smart display shares the panel timing unchanged
         next_hs = (hcnt >= hsd) && (hcnt <= hs_end);
         if (vunit) begin
            next_vs = (vcnt <= vsw);
         end else begin
            next_vs = (vcnt == '0) && (hcnt <= vsw);
         end
         next_de = h_act && v_act;
         next_lsp = (hcnt == asx_m1);
         next_gate = (hcnt >= gr) && (hcnt < gf);
         next_ps = !((hcnt >= pf) && (hcnt < pr));
         // First base cycle of the pixel, in step with the other outputs
         if (pixel_clock && hcnt == rvd) begin
            next_rev = !polarity_flip_signal;
         end
         next_req = pix_tick && h_act && v_act;
         if (next_req) begin
            next_ld = pix_data;
         end
      end else if (en && tv) begin
         // Settings give the 27 MHz strobe rate in this mode
         next_tvls = (hcnt != '0);
         if (!field) begin
            next_tvfs = !((vcnt == '0) && (hcnt <= vsw));
         end else begin
            next_tvfs = !((vcnt == '0) && (hcnt >= vfs_start) &&
                          (hcnt <= vfs_start + vsw));
         end
         next_tvdv = !(h_act && v_act && next_tvls);
         next_req = pix_tick && h_act && v_act && next_tvls;
         if (next_req) begin
            next_ld = {pix_data[7:0], 10'h000};
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pixel_clock <= 1'b0;
         hsync <= 1'b0;
         vsync <= 1'b0;
         data_enable <= 1'b0;
         line_start_pulse <= 1'b0;
         gate_clock_signal <= 1'b0;
         power_save_signal <= 1'b1;
         polarity_flip_signal <= 1'b0;
         tv_output_clock <= 1'b0;
         tv_line_sync <= 1'b1;
         tv_field_sync <= 1'b1;
         tv_data_valid <= 1'b1;
         pix_req <= 1'b0;
         ld <= 18'h0_0000;
      end else begin
         pixel_clock <= next_pclk && !tv;
         hsync <= next_hs;
         vsync <= next_vs;
         data_enable <= next_de;
         line_start_pulse <= next_lsp;
         gate_clock_signal <= next_gate;
         power_save_signal <= next_ps;
         polarity_flip_signal <= next_rev;
         tv_output_clock <= next_pclk && tv;
         tv_line_sync <= next_tvls;
         tv_field_sync <= next_tvfs;
         tv_data_valid <= next_tvdv;
         pix_req <= next_req;
         ld <= next_ld;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_PIX_DIV: assert property (pix_tick |-> if_tick && div_cnt >= pdiv)
      else $error("pixel tick without full divider count");
   AST_LINE_WRAP: assert property (en && pix_tick && hcnt == lw |=> hcnt == '0)
      else $error("line did not wrap at line width");
   AST_HS_END: assert property (en && !tv && $fell(hsync)
      |-> $past(hcnt) == hs_end + W'(1))
      else $error("hsync ended at wrong pixel");
   AST_HS_START: assert property (en && !tv && $rose(hsync) |-> $past(hcnt) == hsd)
      else $error("hsync started at wrong pixel");
   AST_FRAME_WRAP: assert property (en && pix_tick && hcnt == lw && vcnt == fh
      |=> vcnt == '0 && field != $past(field))
      else $error("frame did not wrap at frame height");
   AST_VS_PIX: assert property (en && !tv && !vunit && !$past(vunit) && vsync
      |-> $past(vcnt) == '0)
      else $error("pixel-unit vsync outside first line");
   AST_IF_ACC: assert property (en && iper != 16'h0000 && bper <= iper
      |=> acc < {1'b0, $past(iper)})
      else $error("interface accumulator overran period");
   AST_LSP: assert property ($rose(line_start_pulse) |-> $past(hcnt) == asx_m1)
      else $error("line start pulse at wrong pixel");
   AST_GATE: assert property ($rose(gate_clock_signal) |-> $past(hcnt) == gr)
      else $error("gate clock rose at wrong pixel");
   AST_REV: assert property ($changed(polarity_flip_signal) |-> $past(hcnt) == rvd)
      else $error("polarity flip at wrong pixel");
   AST_TV_LS: assert property ($fell(tv_line_sync) |-> $past(hcnt) == '0)
      else $error("line sync fell away from row start");
   AST_TV_ODD: assert property ($fell(tv_field_sync) && !$past(field) && $past(tv, 2)
      |-> $fell(tv_line_sync))
      else $error("odd field syncs not coincident");
   AST_TV_EVEN: assert property ($fell(tv_field_sync) && $past(field) && $past(tv, 2)
      |-> !$fell(tv_line_sync))
      else $error("even field syncs coincident");
   AST_TV_DV: assert property (!tv_data_valid |-> tv_line_sync)
      else $error("data valid while line sync low");
   AST_IDLE: assert property (!en |=> !hsync && !vsync && tv_line_sync && tv_field_sync
      && hcnt == '0 && vcnt == '0)
      else $error("syncs active while disabled");
endmodule
